// >>> logic/gpc_pkg.sv
// gpc_pkg: offsets, field positions, reset values and decoder time bases
// for the pin-pair configuration slice. No timescale here; packages carry none.
package gpc_pkg;

    // register location and reset image
    localparam logic [7:0]  GPC_CFG_OFFSET = 8'h81;
    localparam logic [15:0] GPC_CFG_RESET  = 16'h8000;
    localparam logic [15:0] GPC_CFG_RO_ONE = 16'h8000;  // bits forced to one on every write

    // field positions inside gpio_pair_config
    localparam int GPC_TOP_BIT      = 15;
    localparam int GPC_SPARE_HI     = 14;
    localparam int GPC_SPARE_LO     = 12;
    localparam int GPC_FMT_ONE      = 11;
    localparam int GPC_FMT_ZERO     = 10;
    localparam int GPC_DIR_ONE      = 9;
    localparam int GPC_DIR_ZERO     = 8;
    localparam int GPC_TB_ONE_LO    = 6;
    localparam int GPC_TB_ZERO_LO   = 4;
    localparam int GPC_DAT_ONE      = 1;
    localparam int GPC_DAT_ZERO     = 0;

    // decoder time bases in master-clock periods
    localparam logic [10:0] GPC_TB_CYC_0 = 11'h010;  // 16
    localparam logic [10:0] GPC_TB_CYC_1 = 11'h040;  // 64
    localparam logic [10:0] GPC_TB_CYC_2 = 11'h100;  // 256
    localparam logic [10:0] GPC_TB_CYC_3 = 11'h400;  // 1024

    // time base code to window length in cycles
    function automatic logic [10:0] gpc_tb_cycles(input logic [1:0] code);
        case (code)
            2'h0:    gpc_tb_cycles = GPC_TB_CYC_0;
            2'h1:    gpc_tb_cycles = GPC_TB_CYC_1;
            2'h2:    gpc_tb_cycles = GPC_TB_CYC_2;
            default: gpc_tb_cycles = GPC_TB_CYC_3;
        endcase
    endfunction

endpackage

// >>> logic/gpc_pwm_decode.sv
// gpc_pwm_decode: recovers a logic level from a pwm waveform by majority
// vote over one time-base window. Assumes sample is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module gpc_pwm_decode (
    // clock and control
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    input  wire logic       enable,
    input  wire logic [1:0] timebase,
    // sampled pin and result
    input  wire logic       sample,
    output logic            level_q
);
    import gpc_pkg::*;

    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic [10:0] high_q;
    logic [10:0] high_d;
    logic        level_d;
    logic [10:0] win;
    logic [10:0] high_now;

    // window counter and high-sample tally; a duty above half decodes as one
    always_comb begin
        win      = gpc_tb_cycles(timebase);
        high_now = high_q + {10'h000, sample};
        cnt_d    = cnt_q;
        high_d   = high_q;
        level_d  = level_q;
        if (!enable) begin
            cnt_d  = 11'h000;
            high_d = 11'h000;
        end else if (cnt_q >= win - 11'h001) begin
            level_d = ({high_now, 1'b0} > {1'b0, win});
            cnt_d   = 11'h000;
            high_d  = 11'h000;
        end else begin
            cnt_d  = cnt_q + 11'h001;
            high_d = high_now;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q   <= 11'h000;
            high_q  <= 11'h000;
            level_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q   <= cnt_d;
            high_q  <= high_d;
            level_q <= level_d;
        end
    end

    // the window never runs past the time base it was counted against; a
    // shorter time base chosen mid-window ends that window on the next edge if cnt_q is already at or past the new win - 1
    chk_window_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && enable
        |=> cnt_q < $past(win))
        else $error("decoder window exceeds time base");

endmodule
`default_nettype wire

// >>> logic/gpc_cfg_top.sv
// gpc_cfg_top: configuration register and pin logic for a pair of
// general-purpose pins. Assumes a register port already decoded from the
// serial host and pins arriving asynchronously to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module gpc_cfg_top (
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // pin zero
    input  wire logic        aux_pin_zero_in,
    output logic             aux_pin_zero_out,
    output logic             aux_pin_zero_oe,
    // pin one
    input  wire logic        aux_pin_one_in,
    output logic             aux_pin_one_out,
    output logic             aux_pin_one_oe,
    // levels seen by the core
    output logic             pin_zero_level,
    output logic             pin_one_level
);
    import gpc_pkg::*;

    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [1:0]  sync1_q;
    logic [1:0]  sync2_q;
    logic [1:0]  out_q;
    logic [1:0]  out_d;
    logic [1:0]  oe_q;
    logic [1:0]  oe_d;
    logic [1:0]  lvl_q;
    logic [1:0]  lvl_d;
    logic [1:0]  dec_lvl;
    logic        hit;
    logic        seen_q;

    // level handed to the core: an output reports its data bit, an input
    // either its synchronised pin or its decoder; shared by both pins
    function automatic logic pick_level(input logic is_out, input logic dat,
                                        input logic use_pwm, input logic dec,
                                        input logic pin);
        pick_level = is_out ? dat : (use_pwm ? dec : pin);
    endfunction

    assign hit = (reg_addr == GPC_CFG_OFFSET);

    // register write and read; top bit forced to one so writes cannot clear it
    always_comb begin
        cfg_d   = cfg_q;
        rdata_d = rdata_q;
        if (reg_wr_en && hit) begin
            cfg_d = reg_wdata | GPC_CFG_RO_ONE;
        end
        if (reg_rd_en && hit) begin
            rdata_d = cfg_q | GPC_CFG_RO_ONE;
        end
    end

    // reset image clears direction and format bits
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q   <= GPC_CFG_RESET;
            rdata_q <= 16'h0000;
        end else if (clk_en) begin
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // two-stage synchroniser; only the second stage feeds any logic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
        end else if (clk_en) begin
            sync1_q <= {aux_pin_one_in, aux_pin_zero_in};
            sync2_q <= sync1_q;
        end
    end

    // one decoder per pin, idle unless the pin is a pwm-format input
    gpc_pwm_decode u_dec_zero (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .enable   (cfg_q[GPC_FMT_ZERO] && !cfg_q[GPC_DIR_ZERO]),
        .timebase (cfg_q[GPC_TB_ZERO_LO+1:GPC_TB_ZERO_LO]),
        .sample   (sync2_q[0]),
        .level_q  (dec_lvl[0])
    );

    gpc_pwm_decode u_dec_one (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .enable   (cfg_q[GPC_FMT_ONE] && !cfg_q[GPC_DIR_ONE]),
        .timebase (cfg_q[GPC_TB_ONE_LO+1:GPC_TB_ONE_LO]),
        .sample   (sync2_q[1]),
        .level_q  (dec_lvl[1])
    );

    // pin drive and core levels; format bits are ignored for outputs, so an
    // output pin only ever carries the static data bit
    always_comb begin
        oe_d  = {cfg_q[GPC_DIR_ONE], cfg_q[GPC_DIR_ZERO]};
        out_d = {cfg_q[GPC_DAT_ONE], cfg_q[GPC_DAT_ZERO]};
        lvl_d[0] = pick_level(cfg_q[GPC_DIR_ZERO], cfg_q[GPC_DAT_ZERO],
                              cfg_q[GPC_FMT_ZERO], dec_lvl[0], sync2_q[0]);
        lvl_d[1] = pick_level(cfg_q[GPC_DIR_ONE], cfg_q[GPC_DAT_ONE],
                              cfg_q[GPC_FMT_ONE], dec_lvl[1], sync2_q[1]);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            oe_q  <= 2'h0;
            out_q <= 2'h0;
            lvl_q <= 2'h0;
        end else if (clk_en) begin
            oe_q  <= oe_d;
            out_q <= out_d;
            lvl_q <= lvl_d;
        end
    end

    assign reg_rdata        = rdata_q;
    assign aux_pin_zero_out = out_q[0];
    assign aux_pin_zero_oe  = oe_q[0];
    assign aux_pin_one_out  = out_q[1];
    assign aux_pin_one_oe   = oe_q[1];
    assign pin_zero_level   = lvl_q[0];
    assign pin_one_level    = lvl_q[1];

    // helper: low until the first enabled edge after reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            seen_q <= 1'b0;
        end else if (clk_en) begin
            seen_q <= 1'b1;
        end
    end

    // register checks; every antecedent but that of chk_fmt_reset carries clk_en since a frozen edge
    // takes nothing, and a check without it would fire on a held strobe
    chk_spare_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && reg_wr_en && hit
        |=> cfg_q[GPC_SPARE_HI:GPC_SPARE_LO] == $past(reg_wdata[GPC_SPARE_HI:GPC_SPARE_LO]))
        else $error("spare bits not stored");

    chk_top_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && reg_wr_en && hit
        |=> cfg_q[GPC_TOP_BIT])
        else $error("top bit cleared by a write");

    chk_top_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && reg_rd_en && hit
        |=> reg_rdata[GPC_TOP_BIT] && cfg_q[GPC_TOP_BIT])
        else $error("top bit did not read one");

    chk_fmt_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !seen_q
        |-> cfg_q == GPC_CFG_RESET)
        else $error("format or direction not cleared by reset");

    // pin checks: core levels, drive and direction
    chk_one_pwm_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !cfg_q[GPC_DIR_ONE] && cfg_q[GPC_FMT_ONE]
        |=> pin_one_level == $past(dec_lvl[1]))
        else $error("pin one pwm level wrong");

    chk_one_static_lvl: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !cfg_q[GPC_DIR_ONE] && !cfg_q[GPC_FMT_ONE]
        |=> pin_one_level == $past(sync2_q[1]))
        else $error("pin one static level wrong");

    chk_zero_pwm_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !cfg_q[GPC_DIR_ZERO] && cfg_q[GPC_FMT_ZERO]
        |=> pin_zero_level == $past(dec_lvl[0]))
        else $error("pin zero pwm level wrong");

    chk_zero_static_lvl: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !cfg_q[GPC_DIR_ZERO] && !cfg_q[GPC_FMT_ZERO]
        |=> pin_zero_level == $past(sync2_q[0]))
        else $error("pin zero static level wrong");

    chk_out_static: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && cfg_q[GPC_DIR_ZERO]
        |=> aux_pin_zero_oe && aux_pin_zero_out == $past(cfg_q[GPC_DAT_ZERO]))
        else $error("pin zero output not static data");

    chk_one_out_static: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && cfg_q[GPC_DIR_ONE]
        |=> aux_pin_one_oe && aux_pin_one_out == $past(cfg_q[GPC_DAT_ONE]))
        else $error("pin one output not static data");

    chk_one_dir_in: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !cfg_q[GPC_DIR_ONE]
        |=> !aux_pin_one_oe)
        else $error("pin one driven while input");

    chk_zero_dir_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en
        |=> aux_pin_zero_oe == $past(cfg_q[GPC_DIR_ZERO]))
        else $error("pin zero drive does not follow direction");

endmodule
`default_nettype wire

// >>> verif/gpc_pin_src.sv
// gpc_pin_src: outside signal source for the pins, static level or pwm
// assumes the bench clock; pwm period is 8 cycles, so it divides every window
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_src (
    // clock and mode
    input  wire logic       clk_sys,
    input  wire logic       pwm_on,
    input  wire logic [2:0] duty,
    input  wire logic       level,
    // pin level offered to the device
    output logic            pin
);
    logic [2:0] ph_q = 3'h0;

    // free running phase; high while phase is below duty
    always_ff @(posedge clk_sys) ph_q <= ph_q + 3'h1;
    assign pin = pwm_on ? (ph_q < duty) : level;
endmodule
`default_nettype wire

// >>> verif/tb_gpc_cfg_top.sv
// tb_gpc_cfg_top: self-checking bench for the pin-pair config slice
// assumes gpc_pkg compiled first and gpc_pin_src as the pin partner
`timescale 1ns/1ps
`default_nettype none
module tb_gpc_cfg_top;
    import gpc_pkg::*;
    logic        clk_sys, reset_n, ce, wr, rd, pwm_on, src_lvl, src, o0, o1, e0, e1, l0, l1;
    logic [2:0]  duty;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata;
    logic [31:0] rnd;
    logic [15:0] exp_q[$];
    int          error_cnt, samples_checked;

    gpc_cfg_top gpc_cfg_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(ce),
        .reg_addr(addr), .reg_wr_en(wr), .reg_rd_en(rd), .reg_wdata(wdata),
        .reg_rdata(rdata), .aux_pin_zero_in(e0 ? o0 : src), .aux_pin_zero_out(o0),
        .aux_pin_zero_oe(e0), .aux_pin_one_in(e1 ? o1 : src), .aux_pin_one_out(o1),
        .aux_pin_one_oe(e1), .pin_zero_level(l0), .pin_one_level(l1));
    gpc_pin_src gpc_pin_src_i (.clk_sys(clk_sys), .pwm_on(pwm_on), .duty(duty),
        .level(src_lvl), .pin(src));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // a spare edge after each read keeps reads apart for the watcher
    task automatic rd_reg(input logic [15:0] e);
        @(posedge clk_sys);
        addr <= GPC_CFG_OFFSET;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // read watcher: data shows one edge after the taking edge
    initial begin
        logic take, pend;
        pend = 1'b0;
        forever begin
            @(posedge clk_sys);
            take = rd && ce && addr == GPC_CFG_OFFSET;
            #1;
            if (pend) chk("rdata", rdata, exp_q.pop_front());
            pend = take;
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end

    // main sequence
    initial begin
        {reset_n, wr, rd, pwm_on, src_lvl, duty, addr, wdata} = '0;
        ce = 1'b1;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(62));
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_reg(16'h8000);
        wr_reg(8'h80, 16'h7FFF);
        rd_reg(16'h8000);
        wr_reg(GPC_CFG_OFFSET, 16'h7000);
        rd_reg(16'hF000);
        repeat (4) begin
            rnd = $urandom;
            wr_reg(GPC_CFG_OFFSET, rnd[15:0]);
            rd_reg(rnd[15:0] | 16'h8000);
        end
        // reset in mid-run brings back the reset image; one edge first so
        // the last read is checked before reset clears the read data
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_reg(16'h8000);
        // a write while the clock enable is low must leave the register alone
        ce <= 1'b0;
        wr_reg(GPC_CFG_OFFSET, 16'h0300);
        ce <= 1'b1;
        rd_reg(16'h8000);
        // outputs with format set and a pwm source: must stay static
        pwm_on <= 1'b1;
        duty <= 3'h6;
        wr_reg(GPC_CFG_OFFSET, 16'h0F01);
        repeat (2) @(posedge clk_sys);
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            chk("drive", 16'({e1, e0, o1, o0, l1, l0}), 16'h0035);
        end
        // static inputs
        pwm_on <= 1'b0;
        wr_reg(GPC_CFG_OFFSET, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            src_lvl <= i[0];
            repeat (4) @(posedge clk_sys);
            #1;
            chk("static", 16'({e1, e0, l1, l0}), 16'({2'b00, i[0], i[0]}));
        end
        // pwm decoding over every time base, majority high then low
        pwm_on <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            for (int d = 6; d > 0; d -= 4) begin
                duty <= 3'(d);
                wr_reg(GPC_CFG_OFFSET, 16'h0C00 | 16'(c << 6) | 16'(c << 4));
                repeat (2 * (16 << (2 * c)) + 4) @(posedge clk_sys);
                #1;
                chk("pwm", 16'({l1, l0}), (d > 4) ? 16'h0003 : 16'h0000);
            end
        end
        give_verdict();
    end
endmodule
`default_nettype wire
